// [gated_intensifier_timing.sv]
// gate-mode timing sequencer: gate, aux and bias pulses, readout interlock
`timescale 1ns/1ps
`default_nettype none
module gated_intensifier_timing
	import gate_timing_pkg::*;
#(
	parameter int BRK_PERIOD = BRK_PERIOD_CYC
) (
	// clock and reset
	input  wire logic          REF_CLK,
	input  wire logic          RST_N,
	// pins from outside the clock domain
	input  wire logic          TRIG_IN,
	input  wire logic          IIT_ENABLE,
	input  wire logic          OVERLIGHT_ALARM,
	input  wire logic          GATE_MODE,
	input  wire logic          BRACKET_REQ,
	input  wire logic          GEN3_FITTED,
	// settings from same-clock control logic, in cycles
	input  wire logic [CW-1:0] GATE_DELAY,
	input  wire logic [CW-1:0] GATE_WIDTH,
	input  wire logic [CW-1:0] AUX_DELAY,
	input  wire logic [CW-1:0] AUX_WIDTH,
	input  wire logic [CW-1:0] ACCUM_COUNT,
	input  wire logic [CW-1:0] EXPOSURE_SET,
	input  wire logic          READOUT_DONE,
	// timing pulses and bias drives
	output logic               GATE_START_PLS,
	output logic               GATE_STOP_PLS,
	output logic               AUX_OUT,
	output logic               PC_BIAS_ON,
	output logic               MCP_BIAS_ON,
	// readout and status
	output logic               READOUT_START,
	output logic               SEQ_BUSY,
	output logic               BRACKET_ACTIVE,
	output logic [CW-1:0]      EXPOSURE_TIME,
	output logic               CONT_CLEAN_EN,
	output logic               SHUTTER_OPEN
);
	typedef struct packed {
		seq_st_t         st;
		logic [TW-1:0]   t;
		logic [CW-1:0]   gcnt;
		logic [CW-1:0]   gap;
		logic [CW-1:0]   span;
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] f;
		logic            trig_prev;
		logic            brk;
		logic            pc;
		logic            mcp;
		logic            gstart;
		logic            gstop;
		logic            aux;
		logic            rd;
		logic            busy;
		logic [2:0]      seen;
		logic [CW-1:0]   expo;
		logic            clean;
		logic            shut;
	} core_t;

	core_t state_r;
	core_t state_nxt;

	logic [TW-1:0] on_at;
	logic [TW-1:0] off_at;
	logic [TW-1:0] aux_on;
	logic [TW-1:0] aux_off;
	logic [TW-1:0] mcp_off;
	logic [TW-1:0] end_at;
	logic [CW-1:0] period;
	logic [CW-1:0] accum;
	logic          accept;
	logic          done;
	logic          last;
	logic          pc_ok;
	logic          brk_eff;

	always_comb begin
		brk_eff = state_r.f[P_BRK] & ~state_r.f[P_GEN3];
		on_at = TW'(INS_CYC) + {4'h0, GATE_DELAY} + (state_r.brk ? TW'(BRK_ADD_CYC) : '0);
		if (state_r.brk && on_at < TW'(BRK_MIN_CYC)) begin
			on_at = TW'(BRK_MIN_CYC);
		end
		off_at  = on_at + ((GATE_WIDTH == '0) ? TW'(1) : {4'h0, GATE_WIDTH});
		aux_on  = {4'h0, AUX_DELAY};
		aux_off = aux_on + ((AUX_WIDTH == '0) ? TW'(1) : {4'h0, AUX_WIDTH});
		mcp_off = off_at + TW'(MCP_TAIL_CYC);
		end_at  = state_r.brk ? mcp_off : off_at;
		if (aux_off > end_at) begin
			end_at = aux_off;
		end
		// faster triggers are dropped, not queued
		period  = brk_eff ? CW'(BRK_PERIOD) : CW'(NOBRK_PERIOD_CYC);
		accum   = (ACCUM_COUNT == '0) ? CW'(1) : ACCUM_COUNT;
		accept  = (state_r.st == S_IDLE) && state_r.f[P_MODE] && state_r.f[P_TRIG]
			&& !state_r.trig_prev && (state_r.gap >= period);
		done    = (state_r.st == S_SEQ) && (state_r.t >= end_at);
		last    = (state_r.gcnt + CW'(1)) >= accum;
		pc_ok   = state_r.f[P_IIT] && !state_r.f[P_ALARM];
	end

	always_comb begin
		state_nxt = state_r;
		// first stage only feeds the second
		state_nxt.s1 = {GEN3_FITTED, BRACKET_REQ, GATE_MODE, OVERLIGHT_ALARM, IIT_ENABLE, TRIG_IN};
		state_nxt.s2 = state_r.s1;
		state_nxt.s3 = state_r.s2;
		for (int i = 0; i < NPIN; i++) begin
			if (state_r.s2[i] == state_r.s3[i]) begin
				state_nxt.f[i] = state_r.s3[i];
			end
		end
		state_nxt.trig_prev = state_r.f[P_TRIG];
		state_nxt.gstart = 1'b0;
		state_nxt.gstop  = 1'b0;
		state_nxt.rd     = 1'b0;
		state_nxt.pc     = 1'b0;
		if (state_r.gap != '1) begin
			state_nxt.gap = state_r.gap + CW'(1);
		end
		if (state_r.span != '1) begin
			state_nxt.span = state_r.span + CW'(1);
		end
		unique case (state_r.st)
			S_IDLE: begin
				state_nxt.brk = brk_eff;
				state_nxt.mcp = brk_eff ? 1'b0 : state_r.f[P_IIT];
				state_nxt.aux = 1'b0;
				if (accept) begin
					state_nxt.st   = S_SEQ;
					state_nxt.t    = '0;
					state_nxt.gap  = '0;
					state_nxt.seen = 3'h0;
					// with bracketing, mcp rises at sequence start, on_at plus one cycles ahead of the photocathode gate
					state_nxt.mcp  = brk_eff ? state_r.f[P_IIT] : state_r.f[P_IIT];
				end
			end
			S_SEQ: begin
				state_nxt.t      = state_r.t + TW'(1);
				state_nxt.gstart = (state_r.t == on_at);
				state_nxt.gstop  = (state_r.t == off_at);
				state_nxt.aux    = (state_r.t >= aux_on) && (state_r.t < aux_off);
				state_nxt.pc     = pc_ok && (state_r.t >= on_at) && (state_r.t < off_at);
				state_nxt.mcp    = state_r.brk ? (pc_ok && state_r.t < mcp_off)
					: state_r.f[P_IIT];
				// next values, so a stop pulse issued on the last cycle still counts
				state_nxt.seen   = state_r.seen
					| {state_nxt.aux, state_nxt.gstop, state_nxt.gstart};
				if (done) begin
					state_nxt.aux = 1'b0;
					if (last) begin
						state_nxt.st   = S_READ;
						state_nxt.rd   = 1'b1;
						state_nxt.gcnt = '0;
					end else begin
						state_nxt.st   = S_IDLE;
						state_nxt.gcnt = state_r.gcnt + CW'(1);
					end
				end
			end
			S_READ: begin
				state_nxt.pc = 1'b0;
				state_nxt.mcp = state_r.brk ? 1'b0 : state_r.f[P_IIT];
				if (READOUT_DONE && !state_r.rd) begin
					state_nxt.st = S_IDLE;
				end
			end
		endcase
		if (!state_r.f[P_MODE] && state_r.st == S_IDLE) begin
			state_nxt.gcnt = '0;
		end
		state_nxt.busy  = (state_nxt.st == S_SEQ);
		// cycles since the last sequence began, watched by the rate check
		if (state_nxt.busy && !state_r.busy) begin
			state_nxt.span = '0;
		end
		// gate mode pins these; otherwise EXPOSURE_SET passes through, clean is on and the shutter closed
		state_nxt.expo  = state_r.f[P_MODE] ? EXPO_GATED : EXPOSURE_SET;
		state_nxt.clean = !state_r.f[P_MODE];
		state_nxt.shut  = state_r.f[P_MODE];
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state_r      <= '0;
			state_r.st   <= S_IDLE;
			state_r.expo <= EXPO_GATED;
			state_r.clean <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign GATE_START_PLS = state_r.gstart;
	assign GATE_STOP_PLS  = state_r.gstop;
	assign AUX_OUT        = state_r.aux;
	assign PC_BIAS_ON     = state_r.pc;
	assign MCP_BIAS_ON    = state_r.mcp;
	assign READOUT_START  = state_r.rd;
	assign SEQ_BUSY       = state_r.busy;
	assign BRACKET_ACTIVE = state_r.brk;
	assign EXPOSURE_TIME  = state_r.expo;
	assign CONT_CLEAN_EN  = state_r.clean;
	assign SHUTTER_OPEN   = state_r.shut;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	a_readout_after_seq: assert property (done && last |=> READOUT_START && !SEQ_BUSY)
		else $error("readout not started after final sequence");
	a_no_read_busy: assert property (READOUT_START |-> !SEQ_BUSY && $past(SEQ_BUSY))
		else $error("readout started while sequence busy");
	a_pc_off_read: assert property (state_r.st == S_READ |-> !PC_BIAS_ON)
		else $error("photocathode on during readout");
	a_seq_pulses: assert property ($fell(SEQ_BUSY) |=> state_r.seen == 3'h7)
		else $error("sequence missing start, stop or aux pulse");
	a_gate_forced: assert property (state_r.f[P_MODE] |=>
		EXPOSURE_TIME == EXPO_GATED && !CONT_CLEAN_EN && SHUTTER_OPEN)
		else $error("gate mode settings not forced");
	a_accum_hold: assert property (done && !last |=> !READOUT_START && state_r.st == S_IDLE)
		else $error("readout before accumulation complete");
	a_mcp_idle_off: assert property (state_r.st == S_IDLE && $past(state_r.st) == S_IDLE
		&& state_r.brk && $past(state_r.brk) |-> !MCP_BIAS_ON)
		else $error("mcp on outside bracket");
	a_mcp_lead: assert property ($rose(PC_BIAS_ON) && state_r.brk |->
		$past(MCP_BIAS_ON, MCP_LEAD_CYC))
		else $error("mcp lead before gate too short");
	a_min_delay: assert property (GATE_START_PLS |->
		$past(state_r.t) >= (state_r.brk ? TW'(BRK_MIN_CYC) : TW'(INS_CYC)))
		else $error("trigger to gate delay below minimum");
	a_rep_cap: assert property ($rose(SEQ_BUSY) |-> $past(state_r.span) >= $past(period))
		else $error("trigger accepted above repetition cap");
	a_gen3_nobrk: assert property (state_r.f[P_GEN3] && state_r.st == S_IDLE |=>
		!BRACKET_ACTIVE)
		else $error("bracket active with gen3 intensifier");
	a_pc_disabled: assert property (!state_r.f[P_IIT] || state_r.f[P_ALARM] |=>
		!PC_BIAS_ON)
		else $error("photocathode on while disabled or alarmed");
	a_mcp_cont: assert property (!state_r.brk && state_r.f[P_IIT] && state_r.st != S_IDLE
		|=> MCP_BIAS_ON)
		else $error("mcp not continuous without bracket");

	c_readout: cover property (READOUT_START);
	c_bracket_gate: cover property (state_r.brk && $rose(PC_BIAS_ON));
	c_accum_two: cover property (done && !last ##[1:1000] done && last);
endmodule : gated_intensifier_timing
`default_nettype wire

// [gate_timing_pkg.sv]
// constants and types for the gated intensifier timing sequencer
`default_nettype none
package gate_timing_pkg;
	localparam longint CLK_HZ        = 200_000_000;
	localparam int     CLK_PS        = 5000;
	localparam int     TW            = 20;
	localparam int     CW            = 16;
	// times in their own units
	localparam int     INS_NS        = 25;
	localparam int     BRK_ADD_NS    = 10;
	localparam int     BRK_MIN_NS    = 35;
	localparam int     MCP_LEAD_NS   = 35;
	localparam int     MCP_TAIL_NS   = 1000;
	localparam longint BRK_RATE_CHZ  = 625000;
	localparam longint NOBRK_RATE_HZ = 1_000_000;
	// derived cycle counts, least times rounded up
	localparam int     INS_CYC       = (INS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int     BRK_ADD_CYC   = (BRK_ADD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int     BRK_MIN_CYC   = (BRK_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int     MCP_LEAD_CYC  = (MCP_LEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int     MCP_TAIL_CYC  = (MCP_TAIL_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int     BRK_PERIOD_CYC =
		int'((CLK_HZ * 100 + BRK_RATE_CHZ - 1) / BRK_RATE_CHZ);
	localparam int     NOBRK_PERIOD_CYC =
		int'((CLK_HZ + NOBRK_RATE_HZ - 1) / NOBRK_RATE_HZ);
	// reset values
	localparam logic [CW-1:0] EXPO_GATED = 16'h0000;
	// synchronised pin positions
	localparam int     P_TRIG  = 0;
	localparam int     P_IIT   = 1;
	localparam int     P_ALARM = 2;
	localparam int     P_MODE  = 3;
	localparam int     P_BRK   = 4;
	localparam int     P_GEN3  = 5;
	localparam int     NPIN    = 6;

	typedef enum logic [1:0] {
		S_IDLE,
		S_SEQ,
		S_READ
	} seq_st_t;
endpackage : gate_timing_pkg
`default_nettype wire

// [far_side.sv]
// trigger source and readout responder beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module far_side (
	// clock
	input  wire logic clk,
	// requests from the bench and the sequencer
	input  wire logic fire,
	input  wire logic ro_start,
	// drives toward the sequencer
	output logic      trig,
	output logic      ro_done
);
	int tcnt = 0;
	int rcnt = 0;
	// held 8 cycles so the pin filter sees a clean edge
	assign trig = tcnt != 0;
	always @(negedge clk) begin
		tcnt <= fire ? 8 : (tcnt != 0 ? tcnt - 1 : 0);
		rcnt <= ro_start ? 1 + $urandom % 40 : (rcnt != 0 ? rcnt - 1 : 0);
		ro_done <= rcnt == 1;
	end
endmodule : far_side
`default_nettype wire

// [testbench.sv]
// self-checking bench for the gate timing sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
	import gate_timing_pkg::*;
;
	logic clk = 0, rst_n = 0, fire = 0, iit = 1, alarm = 0, gmode = 0, brk = 0, gen3 = 0;
	logic [CW-1:0] gd = '0, gw = '0, ad = '0, aw = '0, acc = 16'h0001, exps = '0;
	logic gs, gp, aux, pc, mcp, ro_start, busy, bact, clean, shut, trig, ro_done;
	logic [CW-1:0] expo;
	int t, lead, stop_at, n_gs, n_gp, pc_n, aux_n, mcp_pre, n_ro, bad, in_rd;
	int n_mismatch = 0, check_count = 0, cyc = 0, exp_ro = 0, in_frame = 0;

	always #2.5 clk = ~clk;

	gated_intensifier_timing #(.BRK_PERIOD(300)) dut_u (
		.REF_CLK(clk), .RST_N(rst_n), .TRIG_IN(trig), .IIT_ENABLE(iit),
		.OVERLIGHT_ALARM(alarm), .GATE_MODE(gmode), .BRACKET_REQ(brk),
		.GEN3_FITTED(gen3), .GATE_DELAY(gd), .GATE_WIDTH(gw), .AUX_DELAY(ad),
		.AUX_WIDTH(aw), .ACCUM_COUNT(acc), .EXPOSURE_SET(exps), .READOUT_DONE(ro_done),
		.GATE_START_PLS(gs), .GATE_STOP_PLS(gp), .AUX_OUT(aux), .PC_BIAS_ON(pc),
		.MCP_BIAS_ON(mcp), .READOUT_START(ro_start), .SEQ_BUSY(busy),
		.BRACKET_ACTIVE(bact), .EXPOSURE_TIME(expo), .CONT_CLEAN_EN(clean),
		.SHUTTER_OPEN(shut));

	far_side far_u (.clk(clk), .fire(fire), .ro_start(ro_start), .trig(trig),
		.ro_done(ro_done));

	// counters cleared by each trigger request, readout tallies kept whole run
	initial {t, lead, stop_at, n_gs, n_gp, pc_n, aux_n, mcp_pre, n_ro, bad, in_rd} = '0;
	always @(negedge clk) begin
		t <= busy ? t + 1 : 0;
		if (fire) begin
			{n_gs, n_gp, pc_n, aux_n, mcp_pre} <= '0;
		end else begin
			if (gs) begin
				lead <= t;
				n_gs <= n_gs + 1;
			end
			if (gp) begin
				stop_at <= t;
				n_gp <= n_gp + 1;
			end
			pc_n <= pc_n + pc;
			aux_n <= aux_n + aux;
			if (mcp && busy && !pc && n_gs == 0) mcp_pre <= mcp_pre + 1;
		end
		if (ro_start) n_ro <= n_ro + 1;
		in_rd <= ro_start ? 1 : (ro_done ? 0 : in_rd);
		if ((pc && (in_rd != 0 || ro_start)) || (ro_start && busy)) bad <= bad + 1;
	end

	function automatic int eff(input logic [CW-1:0] v);
		return v == 0 ? 1 : int'(v);
	endfunction : eff

	// start pulse is registered one cycle after the count reaches the gate point
	function automatic int exp_lead(input bit b, input logic [CW-1:0] d);
		return INS_CYC + int'(d) + 1 + (b ? BRK_ADD_CYC : 0);
	endfunction : exp_lead

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	// one trigger, then wait out the gap; run says whether it must be taken
	task automatic seq(input int gap, input bit run);
		int k;
		int e;
		bit b;
		fire <= 1'b1;
		@(negedge clk);
		fire <= 1'b0;
		k = 0;
		while (!busy && k < 20) begin
			@(negedge clk);
			k++;
		end
		repeat (gap - k) @(negedge clk);
		// settings were set just before the call, read them once they stand
		b = brk && !gen3;
		e = exp_lead(b, gd);
		chk("gate_starts", run, n_gs);
		if (run) begin
			chk("gate_stops", 1, n_gp);
			chk("gate_lead", e, lead);
			chk("gate_stop_at", e + eff(gw), stop_at);
			chk("pc_cycles", (iit && !alarm) ? eff(gw) : 0, pc_n);
			chk("aux_cycles", eff(aw), aux_n);
			chk("bracket_active", b, bact);
			chk("mcp_after", b ? 0 : iit, mcp);
			if (b) chk("mcp_lead_ok", 1, mcp_pre >= MCP_LEAD_CYC);
			in_frame++;
			if (in_frame >= eff(acc)) begin
				in_frame = 0;
				exp_ro++;
			end
		end
		chk("readouts", exp_ro, n_ro);
	endtask : seq

	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		void'($urandom(32'hfcb3));
		repeat (8) @(negedge clk);
		rst_n <= 1'b1;
		exps <= 16'($urandom);
		repeat (320) @(negedge clk);
		chk("exposure_free", exps, expo);
		chk("clean_free", 1, clean);
		seq(210, 0);
		gmode <= 1'b1;
		repeat (8) @(negedge clk);
		chk("exposure_gated", 0, expo);
		chk("clean_gated", 0, clean);
		chk("shutter_gated", 1, shut);
		$display("test modes done");
		acc <= 16'h0002;
		for (int i = 0; i < 4; i++) begin
			gd <= 16'($urandom % 21);
			gw <= (i == 0) ? 16'h0000 : 16'(1 + $urandom % 15);
			ad <= 16'($urandom % 25);
			aw <= (i == 1) ? 16'h0000 : 16'(1 + $urandom % 15);
			seq(210, 1);
		end
		$display("test accumulate done");
		// bracket spacing is longer than the last gap, let it run out
		repeat (150) @(negedge clk);
		acc <= 16'h0001;
		brk <= 1'b1;
		gw <= 16'h0001;
		for (int i = 0; i < 2; i++) begin
			gd <= (i == 0) ? 16'h0000 : 16'h0004;
			seq(275, 1);
			seq(320, 0);
		end
		gen3 <= 1'b1;
		seq(320, 1);
		$display("test bracket done");
		{gen3, brk, iit} <= 3'b000;
		seq(210, 1);
		{iit, alarm} <= 2'b11;
		seq(210, 1);
		alarm <= 1'b0;
		chk("interlock_faults", 0, bad);
		$display("test safety done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
